// ### hdl/pio_pkg.sv
// Purpose: Shared constants for the parallel port block.
// Assumes: 12-bit CPU address, 8-bit data, one core clock.
// Notes: Pin vector order is one, six, pwm, analog, video, sync from bit 0.
//
// Contract
// - Special registers low, data buffers high
// - Outputs latched, inputs read live
// - Pin level sampled in read first state
// - Pin output changes in write second state
// - Fixed ports: modify-write reads latch, else pin
// - Reset sets every output latch to one
// - Falling single pin sets interrupt event
// - Pwm port direction bits, reset input
// - Writes reach latch regardless of direction
// - Input-mode bits read pin state
// - Reset clears analog disable and channel
// - Interrupt enable bit selects low analog pin
// - Video port direction bits, reset input
// - Swap bit reorders five shared pins
package pio_pkg;
	localparam logic [11:0] SFR_BASE = 12'h000;
	localparam logic [11:0] SFR_TOP = 12'h03F;
	localparam logic [11:0] DBR_BASE = 12'hF80;
	localparam logic [11:0] DBR_TOP = 12'hFFF;

	localparam logic [11:0] OFS_ONE_BIT_DATA = 12'h002;
	localparam logic [11:0] OFS_SIX_BIT_DATA = 12'h003;
	localparam logic [11:0] OFS_PWM_DATA = 12'h004;
	localparam logic [11:0] OFS_ANALOG_DATA = 12'h005;
	localparam logic [11:0] OFS_VIDEO_DATA = 12'h006;
	localparam logic [11:0] OFS_SYNC_DATA = 12'h007;
	localparam logic [11:0] OFS_PWM_DIR = 12'h00C;
	localparam logic [11:0] OFS_VIDEO_DIR = 12'h00D;
	localparam logic [11:0] OFS_CONV_CTRL = 12'h00E;
	localparam logic [11:0] OFS_PIN_SWAP = 12'h027;
	localparam logic [11:0] OFS_EXT_IRQ_CTRL = 12'h037;

	localparam logic [7:0] LATCH_RESET = 8'hFF;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [4:0] CONV_RESET = 5'h00;
	localparam logic SWAP_RESET = 1'h0;
	localparam logic EXT_LOW_EN_RESET = 1'h0;

	localparam int PIN_SWAP_BIT = 7;
	localparam int ANALOG_DISABLE_BIT = 4;
	localparam int EXT_LOW_EN_BIT = 6;
	localparam int DISPLAY_LSB = 4;

	localparam int PIN_COUNT = 33;
	localparam int POS_ONE = 0;
	localparam int POS_SIX = 1;
	localparam int POS_PWM = 7;
	localparam int POS_ANALOG = 15;
	localparam int POS_VIDEO = 23;
	localparam int POS_SYNC = 31;

	localparam int SWAP_COUNT = 5;
	localparam int SWAP_SIX_LSB = 2;
	localparam int SWAP_IN_ROT = 3;
	localparam int SWAP_OUT_ROT = 2;
endpackage : pio_pkg

// ### hdl/pio_pin_filter.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: A new level is taken once stages two and three agree.
module pio_pin_filter #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins and filtered levels
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= RESET_LEVEL;
			s2_reg <= RESET_LEVEL;
			s3_reg <= RESET_LEVEL;
		end else begin
			s1_reg <= pin_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				level[i] <= RESET_LEVEL[i];
			end else if (s2_reg[i] == s3_reg[i]) begin
				level[i] <= s2_reg[i];
			end
		end
	end
endmodule : pio_pin_filter

// ### hdl/pio_ports.sv
// Purpose: Six parallel ports with latches, direction control and pin swap.
// Assumes: One-cycle read and write strobes from the core on clk.
// Notes: Write lands in the latch at the next edge, on the pin one edge later.
module pio_ports
	import pio_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Core register access
	input wire logic [11:0] bus_addr,
	input wire logic bus_rd,
	input wire logic bus_rmw,
	input wire logic bus_wr,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	// One-bit port pin
	input wire logic single_port_pin_in,
	output logic single_port_pin_out,
	output logic single_port_pin_oe,
	// Six-bit port pins 1 and 0
	input wire logic [1:0] six_port_pin_in,
	output logic [1:0] six_port_pin_out,
	output logic [1:0] six_port_pin_oe,
	// Five swappable pins
	input wire logic [4:0] swap_pin_in,
	output logic [4:0] swap_pin_out,
	output logic [4:0] swap_pin_oe,
	// Analog-capable port pins 6 to 0
	input wire logic [6:0] analog_port_pin_in,
	output logic [6:0] analog_port_pin_out,
	output logic [6:0] analog_port_pin_oe,
	// Pwm port pins
	input wire logic [7:0] pwm_port_pin_in,
	output logic [7:0] pwm_port_pin_out,
	output logic [7:0] pwm_port_pin_oe,
	// Video port pins
	input wire logic [7:0] video_port_pin_in,
	output logic [7:0] video_port_pin_out,
	output logic [7:0] video_port_pin_oe,
	// Sync pair pins
	input wire logic [1:0] sync_pair_pin_in,
	output logic [1:0] sync_pair_pin_out,
	output logic [1:0] sync_pair_pin_oe,
	// Secondary function sources
	input wire logic [7:0] pwm_wave,
	input wire logic serial_clk_release,
	input wire logic serial_data_release,
	input wire logic [3:0] display_rgby,
	input wire logic [3:0] display_output_select,
	// Toward peripherals
	output logic [32:0] port_in_level,
	output logic single_pin_fall,
	output logic ext_irq_low_level,
	output logic analog_input_disable,
	output logic [3:0] analog_channel_select,
	output logic pin_swap_select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic one_latch_reg;
	logic [5:0] six_latch_reg;
	logic [7:0] pwm_latch_reg;
	logic [7:0] analog_latch_reg;
	logic [7:0] video_latch_reg;
	logic [1:0] sync_latch_reg;
	logic [7:0] pwm_dir_reg;
	logic [7:0] video_dir_reg;
	logic [4:0] conv_ctrl_reg;
	logic ext_low_en_reg;
	logic pin_swap_reg;
	logic one_prev_reg;
	logic [32:0] raw_in;
	logic [32:0] lvl;
	logic [32:0] log_val;
	logic [32:0] log_drive;
	logic [4:0] swap_log_in;
	logic [4:0] swap_log_val;
	logic [4:0] swap_log_drive;
	logic [4:0] swap_out_next;
	logic [4:0] swap_oe_next;
	logic [7:0] rd_next;
	logic [7:0] pwm_val;
	logic [7:0] video_val;
	logic [5:0] six_val;
	logic sfr_hit;

	assign sfr_hit = bus_addr <= SFR_TOP;

	// Output latches: preset to one, written whatever the direction
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			one_latch_reg <= LATCH_RESET[0];
			six_latch_reg <= LATCH_RESET[5:0];
			pwm_latch_reg <= LATCH_RESET;
			analog_latch_reg <= LATCH_RESET;
			video_latch_reg <= LATCH_RESET;
			sync_latch_reg <= LATCH_RESET[1:0];
		end else if (bus_wr && sfr_hit) begin
			case (bus_addr)
				OFS_ONE_BIT_DATA: one_latch_reg <= bus_wdata[0];
				OFS_SIX_BIT_DATA: six_latch_reg <= bus_wdata[5:0];
				OFS_PWM_DATA: pwm_latch_reg <= bus_wdata;
				OFS_ANALOG_DATA: analog_latch_reg <= bus_wdata;
				OFS_VIDEO_DATA: video_latch_reg <= bus_wdata;
				OFS_SYNC_DATA: sync_latch_reg <= bus_wdata[1:0];
				default: ;
			endcase
		end
	end

	// Direction registers, cleared to input at reset
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwm_dir_reg <= DIR_RESET;
			video_dir_reg <= DIR_RESET;
		end else if (bus_wr && sfr_hit) begin
			if (bus_addr == OFS_PWM_DIR) begin
				pwm_dir_reg <= bus_wdata;
			end
			if (bus_addr == OFS_VIDEO_DIR) begin
				video_dir_reg <= bus_wdata;
			end
		end
	end

	// Control bits shared with converter, interrupt and swap logic
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_ctrl_reg <= CONV_RESET;
			ext_low_en_reg <= EXT_LOW_EN_RESET;
			pin_swap_reg <= SWAP_RESET;
		end else if (bus_wr && sfr_hit) begin
			if (bus_addr == OFS_CONV_CTRL) begin
				conv_ctrl_reg <= bus_wdata[ANALOG_DISABLE_BIT:0];
			end
			if (bus_addr == OFS_EXT_IRQ_CTRL) begin
				ext_low_en_reg <= bus_wdata[EXT_LOW_EN_BIT];
			end
			if (bus_addr == OFS_PIN_SWAP) begin
				pin_swap_reg <= bus_wdata[PIN_SWAP_BIT];
			end
		end
	end

	assign analog_input_disable = conv_ctrl_reg[ANALOG_DISABLE_BIT];
	assign analog_channel_select = conv_ctrl_reg[3:0];
	assign pin_swap_select = pin_swap_reg;

	// Pin swap, logical order: ext_irq_four, timer4, bus clock, bus data, analog top
	assign swap_log_val = {log_val[POS_ANALOG + 7], log_val[POS_SIX + SWAP_SIX_LSB +: 4]};
	assign swap_log_drive = {log_drive[POS_ANALOG + 7], log_drive[POS_SIX + SWAP_SIX_LSB +: 4]};
	for (genvar i = 0; i < SWAP_COUNT; i++) begin : g_swap
		assign swap_log_in[i] = pin_swap_reg ? swap_pin_in[(i + SWAP_IN_ROT) % SWAP_COUNT] : swap_pin_in[i];
		assign swap_out_next[i] = pin_swap_reg ? swap_log_val[(i + SWAP_OUT_ROT) % SWAP_COUNT] : swap_log_val[i];
		assign swap_oe_next[i] = pin_swap_reg ? swap_log_drive[(i + SWAP_OUT_ROT) % SWAP_COUNT] : swap_log_drive[i];
	end

	assign raw_in = {sync_pair_pin_in, video_port_pin_in, swap_log_in[4], analog_port_pin_in,
		pwm_port_pin_in, swap_log_in[3:0], six_port_pin_in, single_port_pin_in};

	pio_pin_filter #(
		.WIDTH(PIN_COUNT),
		.RESET_LEVEL({PIN_COUNT{1'b1}})
	) u_filter (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_async(raw_in),
		.level(lvl)
	);

	assign port_in_level = lvl;

	// Pin values: open-drain style on fixed ports, direction on pwm and video
	assign six_val = six_latch_reg & {serial_data_release, serial_clk_release, 4'hF};
	assign pwm_val = pwm_latch_reg & pwm_wave;
	for (genvar k = 0; k < 8; k++) begin : g_video
		if (k >= DISPLAY_LSB) begin : g_disp
			assign video_val[k] = display_output_select[k - DISPLAY_LSB] ?
				display_rgby[k - DISPLAY_LSB] : video_latch_reg[k];
		end else begin : g_plain
			assign video_val[k] = video_latch_reg[k];
		end
	end
	assign log_val = {sync_latch_reg, video_val, analog_latch_reg, pwm_val, six_val, one_latch_reg};
	assign log_drive = {~sync_latch_reg, video_dir_reg, ~analog_latch_reg, pwm_dir_reg,
		~six_val, ~one_latch_reg};

	// Pin flops follow the latch one edge later
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			single_port_pin_out <= 1'h1;
			single_port_pin_oe <= 1'h0;
			six_port_pin_out <= 2'h3;
			six_port_pin_oe <= 2'h0;
			swap_pin_out <= 5'h1F;
			swap_pin_oe <= 5'h00;
			analog_port_pin_out <= 7'h7F;
			analog_port_pin_oe <= 7'h00;
			pwm_port_pin_out <= 8'hFF;
			pwm_port_pin_oe <= 8'h00;
			video_port_pin_out <= 8'hFF;
			video_port_pin_oe <= 8'h00;
			sync_pair_pin_out <= 2'h3;
			sync_pair_pin_oe <= 2'h0;
		end else begin
			single_port_pin_out <= log_val[POS_ONE];
			single_port_pin_oe <= log_drive[POS_ONE];
			six_port_pin_out <= log_val[POS_SIX +: 2];
			six_port_pin_oe <= log_drive[POS_SIX +: 2];
			swap_pin_out <= swap_out_next;
			swap_pin_oe <= swap_oe_next;
			analog_port_pin_out <= log_val[POS_ANALOG +: 7];
			analog_port_pin_oe <= log_drive[POS_ANALOG +: 7];
			pwm_port_pin_out <= log_val[POS_PWM +: 8];
			pwm_port_pin_oe <= log_drive[POS_PWM +: 8];
			video_port_pin_out <= log_val[POS_VIDEO +: 8];
			video_port_pin_oe <= log_drive[POS_VIDEO +: 8];
			sync_pair_pin_out <= log_val[POS_SYNC +: 2];
			sync_pair_pin_oe <= log_drive[POS_SYNC +: 2];
		end
	end

	// Read data source per register
	always_comb begin
		rd_next = 8'h00;
		case (bus_addr)
			OFS_ONE_BIT_DATA: rd_next = {7'h00, bus_rmw ? one_latch_reg : lvl[POS_ONE]};
			OFS_SIX_BIT_DATA: rd_next = {2'h0, bus_rmw ? six_latch_reg : lvl[POS_SIX +: 6]};
			OFS_PWM_DATA: rd_next = (pwm_dir_reg & pwm_latch_reg) | (~pwm_dir_reg & lvl[POS_PWM +: 8]);
			OFS_ANALOG_DATA: rd_next = bus_rmw ? analog_latch_reg : lvl[POS_ANALOG +: 8];
			OFS_VIDEO_DATA: rd_next = (video_dir_reg & video_latch_reg) | (~video_dir_reg & lvl[POS_VIDEO +: 8]);
			OFS_SYNC_DATA: rd_next = {6'h00, bus_rmw ? sync_latch_reg : lvl[POS_SYNC +: 2]};
			OFS_VIDEO_DIR: rd_next = video_dir_reg;
			OFS_CONV_CTRL: rd_next = {3'h0, conv_ctrl_reg};
			OFS_PIN_SWAP: rd_next = {pin_swap_reg, 7'h00};
			OFS_EXT_IRQ_CTRL: rd_next = {1'h0, ext_low_en_reg, 6'h00};
			default: rd_next = 8'h00;
		endcase
	end

	// Pin level sampled at the edge that takes the read
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_rdata <= 8'h00;
		end else if (bus_rd) begin
			bus_rdata <= sfr_hit ? rd_next : 8'h00;
		end
	end

	// Falling level on the single pin, whoever drives it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			one_prev_reg <= 1'h1;
			single_pin_fall <= 1'h0;
			ext_irq_low_level <= 1'h1;
		end else begin
			one_prev_reg <= lvl[POS_ONE];
			single_pin_fall <= one_prev_reg & ~lvl[POS_ONE];
			ext_irq_low_level <= ext_low_en_reg ? lvl[POS_ANALOG] : 1'h1;
		end
	end

	sequence s_pwm_wr;
		bus_wr && bus_addr == OFS_PWM_DATA ##1 !(bus_wr && bus_addr == OFS_PWM_DATA);
	endsequence
	sequence s_dir_wr;
		bus_wr && bus_addr == OFS_PWM_DIR ##1 !(bus_wr && bus_addr == OFS_PWM_DIR);
	endsequence

	property p_reset_latch;
		$past(sys_rst) && !sys_rst |-> pwm_port_pin_out == 8'hFF && pwm_port_pin_oe == 8'h00 && !pin_swap_select;
	endproperty
	a_reset_latch: assert property (p_reset_latch) else $error("ports not at reset state");

	property p_reset_ctrl;
		$past(sys_rst) && !sys_rst |-> !analog_input_disable && analog_channel_select == 4'h0 && ext_irq_low_level;
	endproperty
	a_reset_ctrl: assert property (p_reset_ctrl) else $error("converter control not cleared");

	property p_write_s2;
		s_pwm_wr |=> pwm_port_pin_out == ($past(bus_wdata, 2) & $past(pwm_wave));
	endproperty
	a_write_s2: assert property (p_write_s2) else $error("pin not updated two edges after write");

	property p_dir_write;
		s_dir_wr |=> pwm_port_pin_oe == $past(bus_wdata, 2);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("pwm port drive not following direction");

	property p_read_pin;
		bus_rd && !bus_rmw && bus_addr == OFS_ANALOG_DATA |=> bus_rdata == $past(lvl[POS_ANALOG +: 8]);
	endproperty
	a_read_pin: assert property (p_read_pin) else $error("pin read not sampled at request edge");

	property p_read_latch;
		bus_rd && bus_rmw && bus_addr == OFS_ANALOG_DATA |=> bus_rdata == $past(analog_latch_reg);
	endproperty
	a_read_latch: assert property (p_read_latch) else $error("modify read did not return latch");

	property p_read_input_bits;
		bus_rd && bus_addr == OFS_VIDEO_DATA |=>
			(bus_rdata & ~$past(video_dir_reg)) == ($past(lvl[POS_VIDEO +: 8]) & ~$past(video_dir_reg));
	endproperty
	a_read_input_bits: assert property (p_read_input_bits) else $error("input bit not read from pin");

	property p_one_bit_upper;
		bus_rd && bus_addr == OFS_ONE_BIT_DATA |=> bus_rdata[7:1] == 7'h00;
	endproperty
	a_one_bit_upper: assert property (p_one_bit_upper) else $error("one-bit port upper bits not zero");

	property p_fall_event;
		$fell(lvl[POS_ONE]) |=> single_pin_fall ##1 !single_pin_fall;
	endproperty
	a_fall_event: assert property (p_fall_event) else $error("single pin fall not flagged once");

	property p_low_irq_gate;
		!$past(ext_low_en_reg) |-> ext_irq_low_level;
	endproperty
	a_low_irq_gate: assert property (p_low_irq_gate) else $error("low pin interrupt passed while disabled");

	property p_unmapped;
		bus_rd && !sfr_hit |=> bus_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("read outside register space not zero");
endmodule : pio_ports

// ### test/pio_board_model.sv
// Purpose: Board side of the port pins: pull-ups and external drivers.
// Assumes: Every pin has a pull-up; port and board drivers combine wired-and.
// Notes: Pin vectors are in physical order, as laid out by the testbench.
module pio_board_model (
	// Port side
	input wire logic [32:0] port_out,
	input wire logic [32:0] port_oe,
	// External drivers
	input wire logic [32:0] ext_val,
	input wire logic [32:0] ext_en,
	// Resolved levels
	output logic [32:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released lines rise to the pull-up level
	assign pin_level = (port_out | ~port_oe) & (ext_val | ~ext_en);
endmodule : pio_board_model

// ### test/testbench.sv
// Purpose: Self-checking bench for the parallel port block.
// Assumes: Board pins pulled up; the bench acts as the CPU core.
// Notes: Physical pins: one, six 1:0, swap group, analog 6:0, pwm, video, sync.
module testbench
	import pio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] REGS [13] = '{OFS_ONE_BIT_DATA, OFS_SIX_BIT_DATA, OFS_PWM_DATA, OFS_ANALOG_DATA,
		OFS_VIDEO_DATA, OFS_SYNC_DATA, OFS_PWM_DIR, OFS_VIDEO_DIR, OFS_CONV_CTRL, OFS_PIN_SWAP, OFS_EXT_IRQ_CTRL, 12'h008,
		DBR_BASE};
	logic clk;
	logic sys_rst;
	logic [11:0] bus_addr;
	logic bus_rd, bus_rmw, bus_wr;
	logic [7:0] bus_wdata, bus_rdata, pwm_wave, dir4, dir6;
	wire [32:0] p_out, p_oe, pin_level;
	logic [32:0] ext_val, ext_en, port_in_level;
	logic rel_c, rel_d, single_pin_fall, ext_irq_low_level, ain_dis, swap_sel, sw, irqen;
	logic [3:0] rgby, dsel, chan;
	logic [4:0] conv;
	logic [7:0] lat [2:7];
	logic [15:0] lfsr;
	int fails, n_tests;

	pio_ports pio_ports_i (
		.clk(clk), .sys_rst(sys_rst),
		.bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rmw(bus_rmw), .bus_wr(bus_wr),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.single_port_pin_in(pin_level[0]), .single_port_pin_out(p_out[0]), .single_port_pin_oe(p_oe[0]),
		.six_port_pin_in(pin_level[2:1]), .six_port_pin_out(p_out[2:1]), .six_port_pin_oe(p_oe[2:1]),
		.swap_pin_in(pin_level[7:3]), .swap_pin_out(p_out[7:3]), .swap_pin_oe(p_oe[7:3]),
		.analog_port_pin_in(pin_level[14:8]), .analog_port_pin_out(p_out[14:8]), .analog_port_pin_oe(p_oe[14:8]),
		.pwm_port_pin_in(pin_level[22:15]), .pwm_port_pin_out(p_out[22:15]), .pwm_port_pin_oe(p_oe[22:15]),
		.video_port_pin_in(pin_level[30:23]), .video_port_pin_out(p_out[30:23]), .video_port_pin_oe(p_oe[30:23]),
		.sync_pair_pin_in(pin_level[32:31]), .sync_pair_pin_out(p_out[32:31]), .sync_pair_pin_oe(p_oe[32:31]),
		.pwm_wave(pwm_wave), .serial_clk_release(rel_c), .serial_data_release(rel_d),
		.display_rgby(rgby), .display_output_select(dsel),
		.port_in_level(port_in_level), .single_pin_fall(single_pin_fall), .ext_irq_low_level(ext_irq_low_level),
		.analog_input_disable(ain_dis), .analog_channel_select(chan), .pin_swap_select(swap_sel)
	);
	pio_board_model pio_board_model_i (
		.port_out(p_out), .port_oe(p_oe), .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_level)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [7:0] lfsr_byte();
		repeat (8)
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : lfsr_byte

	// Physical pin vector to the logical order of port_in_level
	function automatic logic [32:0] to_logical(input logic [32:0] p, input logic s_sel);
		logic [4:0] l;
		l = s_sel ? {p[5], p[4], p[3], p[7], p[6]} : p[7:3];
		return {p[32:23], l[4], p[14:8], p[22:15], l[3:0], p[2:0]};
	endfunction : to_logical

	function automatic logic [7:0] exp_rd(input logic [11:0] a, input logic rmw);
		logic [32:0] x;
		x = to_logical(ext_val | ~ext_en, sw);
		case (a)
			OFS_ONE_BIT_DATA: return lat[2] & 8'h01 & (rmw ? 8'hFF : {7'h00, x[0]});
			OFS_SIX_BIT_DATA: return lat[3] & 8'h3F & (rmw ? 8'hFF : {2'h0, x[6:1]} & {2'h0, rel_d, rel_c, 4'hF});
			OFS_PWM_DATA: return (dir4 & lat[4]) | (~dir4 & x[14:7]);
			OFS_ANALOG_DATA: return lat[5] & (rmw ? 8'hFF : x[22:15]);
			OFS_VIDEO_DATA: return (dir6 & lat[6]) | (~dir6 & x[30:23]);
			OFS_SYNC_DATA: return lat[7] & 8'h03 & (rmw ? 8'hFF : {6'h00, x[32:31]});
			OFS_VIDEO_DIR: return dir6;
			OFS_CONV_CTRL: return {3'h0, conv};
			OFS_PIN_SWAP: return {sw, 7'h00};
			OFS_EXT_IRQ_CTRL: return {1'b0, irqen, 6'h00};
			default: return 8'h00;
		endcase
	endfunction : exp_rd

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic rmw, output logic [7:0] q);
		@(negedge clk);
		bus_addr = a;
		bus_rmw = rmw;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		q = bus_rdata;
	endtask : rd

	task automatic check_all();
		logic [7:0] q;
		logic [32:0] x;
		repeat (8) @(negedge clk);
		x = to_logical(ext_val | ~ext_en, sw);
		chk(port_in_level, to_logical(pin_level, sw));
		foreach (REGS[i]) begin
			rd(REGS[i], 1'b0, q);
			chk(q, exp_rd(REGS[i], 1'b0));
			rd(REGS[i], 1'b1, q);
			chk(q, exp_rd(REGS[i], 1'b1));
		end
		chk(p_oe[22:15], dir4);
		chk(p_out[22:15], lat[4] & pwm_wave);
		chk(p_oe[30:23], dir6);
		chk(p_out[30:23], {(dsel & rgby) | (~dsel & lat[6][7:4]), lat[6][3:0]});
		chk({ain_dis, chan, swap_sel}, {conv, sw});
		chk(ext_irq_low_level, irqen ? lat[5][0] & x[15] : 1'b1);
	endtask : check_all

	task automatic count_falls(output int n);
		n = 0;
		repeat (12) begin
			@(negedge clk);
			n += (single_pin_fall === 1'b1);
		end
	endtask : count_falls

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	// Run needs a few thousand cycles; cut off far beyond that
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		end_of_test();
	end

	initial begin
		logic [7:0] q;
		logic [39:0] r;
		int n;
		sys_rst = 1'b1;
		{bus_addr, bus_wdata, bus_rd, bus_rmw, bus_wr} = '0;
		{ext_val, ext_en, rgby, dsel, conv, dir4, dir6, sw, irqen} = '0;
		{pwm_wave, rel_c, rel_d} = '1;
		{fails, n_tests} = '0;
		lfsr = 16'h0051;
		foreach (lat[i])
			lat[i] = 8'hFF;
		repeat (12) @(negedge clk);
		chk(p_oe, 33'h0);
		chk(p_out, {33{1'b1}});
		sys_rst = 1'b0;
		check_all();
		for (int k = 0; k < 24; k++) begin
			sw = (k >= 12);
			r = {lfsr_byte(), lfsr_byte(), lfsr_byte(), lfsr_byte(), lfsr_byte()};
			ext_val = r[32:0];
			r = {lfsr_byte(), lfsr_byte(), lfsr_byte(), lfsr_byte(), lfsr_byte()};
			ext_en = r[32:0];
			q = lfsr_byte();
			{rel_c, rel_d, rgby} = q[5:0];
			dsel = q[7:4];
			pwm_wave = lfsr_byte();
			for (int a = 2; a < 8; a++) begin
				lat[a] = (k == 1) ? 8'h00 : lfsr_byte();
				wr(12'(a), lat[a]);
			end
			q = lfsr_byte();
			wr(OFS_PWM_DATA, q);
			chk(p_out[22:15], lat[4] & pwm_wave);
			lat[4] = q;
			@(negedge clk);
			chk(p_out[22:15], lat[4] & pwm_wave);
			dir4 = (k == 1) ? 8'hFF : lfsr_byte();
			wr(OFS_PWM_DIR, dir4);
			dir6 = lfsr_byte();
			wr(OFS_VIDEO_DIR, dir6);
			wr(OFS_PIN_SWAP, {sw, 7'h00});
			q = lfsr_byte();
			conv = q[4:0];
			wr(OFS_CONV_CTRL, q);
			q = lfsr_byte();
			irqen = q[6];
			wr(OFS_EXT_IRQ_CTRL, q);
			check_all();
		end
		// Reset in mid-run must return every mutated register to its reset value
		@(negedge clk);
		sys_rst = 1'b1;
		repeat (3) @(negedge clk);
		chk(p_oe, 33'h0);
		chk(p_out, {33{1'b1}});
		foreach (lat[i])
			lat[i] = 8'hFF;
		{dir4, dir6, conv, sw, irqen} = '0;
		sys_rst = 1'b0;
		check_all();
		ext_en = '0;
		wr(OFS_ONE_BIT_DATA, 8'hFF);
		repeat (8) @(negedge clk);
		wr(OFS_ONE_BIT_DATA, 8'h00);
		count_falls(n);
		chk(n, 1);
		wr(OFS_ONE_BIT_DATA, 8'hFF);
		count_falls(n);
		chk(n, 0);
		end_of_test();
	end
endmodule : testbench
